// *** hw/idcb_exec.sv ***
// Execution unit for decrement, increment, skip variants, accumulator clear,
// watchdog kick and absolute jump.
// Assumes the decoder holds an op steady only while opReady is high.
//
// Behaviour
// - Decrement takes file register 0..127 minus one to the accumulator or file, setting zero.
// - Accumulator clear loads zero into the accumulator and sets the zero flag.
// - Decrement-skip routes its result by the target bit and leaves every status flag alone.
// - A zero decrement-skip result discards the next instruction as a no-op, taking one extra cycle.
// - Watchdog kick zeroes the watchdog counter and its prescaler.
// - Watchdog kick sets the expiry and sleep-entered flags and touches no other status bit.
// - Absolute jump loads its 11-bit literal into program counter bits 10 to 0.
// - Absolute jump loads program counter bits 14 to 11 from page latch bits 6 to 3.
// - Absolute jump always takes two cycles and changes no status flag.
// - Increment adds one with the same routing as decrement and updates the zero flag.
// - Increment-skip adds one, keeps the flags, and skips the next instruction on zero.
`timescale 1ns/1ns
module idcb_exec
  import idcb_pkg::*;
#(
  parameter int PRE_WIDTH = idcb_pkg::PRE_W
)
(
  input  wire logic                         core_clk,
  input  wire logic                         srst,
  input  wire idcb_pkg::idcb_op_t           opCode,
  input  wire logic                         opValid,
  input  wire logic [idcb_pkg::ADDR_W-1:0]  fileAddr,
  input  wire logic                         resultTarget,
  input  wire logic [idcb_pkg::LIT_W-1:0]   branchLiteral,
  input  wire logic [idcb_pkg::LATCH_W-1:0] pageLatch,
  input  wire logic                         watchdogTick,
  output      logic                         opReady,
  output      logic                         flushNext,
  output      logic                         pcLoad,
  output      logic [idcb_pkg::PC_W-1:0]    pcValue,
  output      logic [idcb_pkg::DATA_W-1:0]  accumulatorReg,
  output      logic [idcb_pkg::STATUS_W-1:0] statusReg,
  output      logic [idcb_pkg::WDT_W-1:0]   watchdogCounter,
  output      logic                         fileWrite,
  output      logic [idcb_pkg::ADDR_W-1:0]  fileWrAddr,
  output      logic [idcb_pkg::DATA_W-1:0]  fileWrData
);
  import idcb_pkg::*;

  if (PRE_WIDTH < 1 || PRE_WIDTH > 16)
  begin : g_badPrescale
    $error("PRE_WIDTH out of range");
  end

  idcb_state_t       state_q;
  idcb_state_t       state_d;
  idcb_op_t          op_q;
  logic [ADDR_W-1:0] addr_q;
  logic              target_q;
  logic [PRE_WIDTH-1:0] prescale_q;
  logic [DATA_W-1:0] memRdData;
  logic              fwd_q;
  logic [DATA_W-1:0] fwdData_q;

  // Operand fetch: capture the op, read file data one cycle later
  wire takeOp   = opValid && (state_q == IDCB_ST_IDLE);
  wire isFileOp = (opCode == IDCB_OP_DEC) || (opCode == IDCB_OP_DECSZ) ||
                  (opCode == IDCB_OP_INC) || (opCode == IDCB_OP_INCSZ);
  wire isKick   = takeOp && (opCode == IDCB_OP_KICK);
  wire isClr    = takeOp && (opCode == IDCB_OP_CLRACC);
  wire isJump   = takeOp && (opCode == IDCB_OP_JUMP);

  // Arithmetic in the write state, wrapping naturally at 8 bits
  wire isDecOp  = (op_q == IDCB_OP_DEC) || (op_q == IDCB_OP_DECSZ);
  wire isSkipOp = (op_q == IDCB_OP_DECSZ) || (op_q == IDCB_OP_INCSZ);
  // A write landing on the taking edge is missed by the read; forward it
  wire fwdHit   = fileWrite && (fileWrAddr == fileAddr);
  wire [DATA_W-1:0] operand   = fwd_q ? fwdData_q : memRdData;
  wire [DATA_W-1:0] sumResult = isDecOp ? operand - ONE
                                        : operand + ONE;
  wire resultZero = (sumResult == '0);
  wire inWrite    = (state_q == IDCB_ST_WRITE);
  wire skipHit    = inWrite && isSkipOp && resultZero;
  wire [PC_W-1:0] jumpTarget = {pageLatch[PAGE_HI:PAGE_LO], branchLiteral};

  idcb_file_mem
  #(
    .DATA_W (DATA_W),
    .ADDR_W (ADDR_W)
  )
  u_mem
  (
    .core_clk (core_clk),
    .srst     (srst),
    .rdAddr   (fileAddr),
    .rdData   (memRdData),
    .wrEn     (fileWrite),
    .wrAddr   (fileWrAddr),
    .wrData   (fileWrData)
  );

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      IDCB_ST_IDLE:
      begin
        if (takeOp && isFileOp)
          state_d = IDCB_ST_WRITE;
        else if (isJump)
          state_d = IDCB_ST_JUMP2;
      end
      IDCB_ST_WRITE:
        state_d = skipHit ? IDCB_ST_FLUSH : IDCB_ST_IDLE;
      IDCB_ST_FLUSH:
        state_d = IDCB_ST_IDLE;
      IDCB_ST_JUMP2:
        state_d = IDCB_ST_IDLE;
      default:
        state_d = IDCB_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state_q  <= IDCB_ST_IDLE;
      op_q     <= IDCB_OP_NONE;
      addr_q   <= '0;
      target_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (takeOp)
      begin
        op_q     <= opCode;
        addr_q   <= fileAddr;
        target_q <= resultTarget;
      end
    end
  end

  // Forward capture runs every edge; only the taking edge's value is used
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      fwd_q     <= 1'b0;
      fwdData_q <= '0;
    end
    else
    begin
      fwd_q     <= fwdHit;
      fwdData_q <= fileWrData;
    end
  end

  // Ready only in idle, so a busy cycle stalls the decoder
  always_ff @(posedge core_clk)
  begin
    if (srst)
      opReady <= 1'b0;
    else
      opReady <= (state_d == IDCB_ST_IDLE);
  end

  // Flush pulse tells fetch to replace the next word with a no-op
  always_ff @(posedge core_clk)
  begin
    if (srst)
      flushNext <= 1'b0;
    else
      flushNext <= skipHit;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pcLoad  <= 1'b0;
      pcValue <= PC_RST;
    end
    else
    begin
      pcLoad <= isJump;
      if (isJump)
        pcValue <= jumpTarget;
    end
  end

  // Result routing: target bit low to accumulator, high to file
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      fileWrite  <= 1'b0;
      fileWrAddr <= '0;
      fileWrData <= '0;
    end
    else
    begin
      fileWrite <= inWrite && target_q;
      if (inWrite)
      begin
        fileWrAddr <= addr_q;
        fileWrData <= sumResult;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      accumulatorReg <= ACC_RST;
    else if (isClr)
      accumulatorReg <= '0;
    else if (inWrite && !target_q)
      accumulatorReg <= sumResult;
  end

  // Zero flag only for the non-skip forms; jump leaves all flags
  always_ff @(posedge core_clk)
  begin
    if (srst)
      statusReg <= STATUS_RST;
    else
    begin
      if (isClr)
        statusReg[ST_ZERO] <= 1'b1;
      else if (inWrite && !isSkipOp)
        statusReg[ST_ZERO] <= resultZero;
      if (isKick)
      begin
        statusReg[ST_EXPIRY] <= 1'b1;
        statusReg[ST_SLEEP]  <= 1'b1;
      end
    end
  end

  // Watchdog model: prescaler divides the tick, kick wins over counting
  always_ff @(posedge core_clk)
  begin
    if (srst || isKick)
    begin
      prescale_q      <= '0;
      watchdogCounter <= WDT_ZERO;
    end
    else if (watchdogTick)
    begin
      prescale_q <= prescale_q + 1'b1;
      if (&prescale_q)
        watchdogCounter <= watchdogCounter + 1'b1;
    end
  end

endmodule : idcb_exec

// *** hw/idcb_pkg.sv ***
// Package for the inc/dec/clear/branch execution block.
// Assumes a single core clock domain and a synchronous active-high reset.
package idcb_pkg;

  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 7;
  localparam int LIT_W       = 11;
  localparam int PC_W        = 15;
  localparam int LATCH_W     = 7;
  localparam int WDT_W       = 8;
  localparam int PRE_W       = 8;
  localparam int MEM_DEPTH   = 128;

  // Page latch field feeding the upper program counter bits
  localparam int PAGE_LO     = 3;
  localparam int PAGE_HI     = 6;

  // Status bit positions
  localparam int ST_ZERO     = 2;
  localparam int ST_SLEEP    = 3;
  localparam int ST_EXPIRY   = 4;
  localparam int STATUS_W    = 8;

  localparam logic [DATA_W-1:0]   ACC_RST    = 8'h00;
  localparam logic [STATUS_W-1:0] STATUS_RST = 8'h18;
  localparam logic [PC_W-1:0]     PC_RST     = 15'h0000;
  localparam logic [WDT_W-1:0]    WDT_ZERO   = 8'h00;
  localparam logic [PRE_W-1:0]    PRE_ZERO   = 8'h00;
  localparam logic [DATA_W-1:0]   ONE        = 8'h01;

  typedef enum logic [2:0]
  {
    IDCB_OP_NONE   = 3'h0,
    IDCB_OP_DEC    = 3'h1,
    IDCB_OP_DECSZ  = 3'h2,
    IDCB_OP_INC    = 3'h3,
    IDCB_OP_INCSZ  = 3'h4,
    IDCB_OP_CLRACC = 3'h5,
    IDCB_OP_KICK   = 3'h6,
    IDCB_OP_JUMP   = 3'h7
  } idcb_op_t;

  typedef enum logic [3:0]
  {
    IDCB_ST_IDLE  = 4'b0001,
    IDCB_ST_WRITE = 4'b0010,
    IDCB_ST_FLUSH = 4'b0100,
    IDCB_ST_JUMP2 = 4'b1000
  } idcb_state_t;

endpackage : idcb_pkg

// *** hw/idcb_file_mem.sv ***
// File register memory with registered read data.
// Assumes reads are addressed one cycle ahead of use and reset clears every cell.
`timescale 1ns/1ns
module idcb_file_mem
#(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 7
)
(
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] rdAddr,
  output      logic [DATA_W-1:0] rdData,
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [DATA_W-1:0] wrData
);

  localparam int DEPTH = 1 << ADDR_W;

  logic [DATA_W-1:0] memArray [0:DEPTH-1];

  if (DATA_W < 1 || ADDR_W < 1)
  begin : g_badSize
    $error("idcb_file_mem size out of range");
  end

  // Cleared on reset so results never start unknown; rules out a plain RAM macro
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      for (int k = 0; k < DEPTH; k++)
        memArray[k] <= '0;
      rdData <= '0;
    end
    else
    begin
      if (wrEn)
        memArray[wrAddr] <= wrData;
      rdData <= memArray[rdAddr];
    end
  end

endmodule : idcb_file_mem

// *** test/idcb_exec_chk.sv ***
// Port checker for the execution unit.
// Assumes binding onto idcb_exec, one core clock.
`timescale 1ns/1ns
module idcb_exec_chk
  import idcb_pkg::*;
(
  input wire logic                          core_clk,
  input wire logic                          srst,
  input wire idcb_pkg::idcb_op_t            opCode,
  input wire logic                          opValid,
  input wire logic                          opReady,
  input wire logic                          flushNext,
  input wire logic                          pcLoad,
  input wire logic [idcb_pkg::PC_W-1:0]     pcValue,
  input wire logic [idcb_pkg::DATA_W-1:0]   accumulatorReg,
  input wire logic [idcb_pkg::STATUS_W-1:0] statusReg,
  input wire logic [idcb_pkg::WDT_W-1:0]    watchdogCounter,
  input wire logic                          fileWrite,
  input wire logic [idcb_pkg::DATA_W-1:0]   fileWrData,
  input wire logic [idcb_pkg::LIT_W-1:0]    branchLiteral,
  input wire logic [idcb_pkg::LATCH_W-1:0]  pageLatch
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic            take;
  logic [PC_W-1:0] jumpPc_q;
  assign take = opValid && opReady;
  // Jump target as seen at the taking edge
  always_ff @(posedge core_clk)
  begin
    jumpPc_q <= {pageLatch[PAGE_HI:PAGE_LO], branchLiteral};
  end
  a_clear_acc_zero: assert property (take && opCode == IDCB_OP_CLRACC |=>
    accumulatorReg == 8'h00 && statusReg[ST_ZERO]) else $error("acc clear wrong");
  a_kick_wdt_zero: assert property (take && opCode == IDCB_OP_KICK |=>
    watchdogCounter == 8'h00) else $error("watchdog not cleared");
  a_kick_status_set: assert property (take && opCode == IDCB_OP_KICK |=>
    statusReg[ST_EXPIRY] && statusReg[ST_SLEEP] && $stable(statusReg[ST_ZERO]))
    else $error("kick status wrong");
  a_jump_pc_load: assert property (take && opCode == IDCB_OP_JUMP |=>
    pcLoad && pcValue == jumpPc_q) else $error("jump target wrong");
  a_jump_two_cycle: assert property (take && opCode == IDCB_OP_JUMP |=>
    !opReady && $stable(statusReg) ##1 opReady && $stable(statusReg))
    else $error("jump timing or flags wrong");
  a_skip_flags_kept: assert property (take && opCode inside {IDCB_OP_DECSZ,
    IDCB_OP_INCSZ} |=> $stable(statusReg)[*2]) else $error("skip op changed status");
  a_flush_on_zero: assert property (flushNext |->
    (fileWrite ? fileWrData : accumulatorReg) == 8'h00) else $error("flush on nonzero");
  a_flush_skip_only: assert property (flushNext |->
    $past(opCode, 2) inside {IDCB_OP_DECSZ, IDCB_OP_INCSZ}) else $error("flush wrong op");
  c_flush_seen: cover property (flushNext);
  c_jump_seen: cover property (pcLoad);
  c_kick_seen: cover property (take && opCode == IDCB_OP_KICK);
endmodule : idcb_exec_chk

bind idcb_exec idcb_exec_chk chk (.core_clk, .srst, .opCode, .opValid, .opReady, .flushNext,
  .pcLoad, .pcValue, .accumulatorReg, .statusReg, .watchdogCounter, .fileWrite, .fileWrData,
  .branchLiteral, .pageLatch);

// *** test/inc_dec_clear_branch_exec_test.sv ***
// Self-checking bench for idcb_exec.
// Assumes reset clears the file memory; cell 7f is walked round by wrapping.
`timescale 1ns/1ns
module inc_dec_clear_branch_exec_test;
  import idcb_pkg::*;
  logic core_clk = 0, srst = 1, opValid = 0, resultTarget = 0, watchdogTick = 1;
  idcb_op_t            opCode = IDCB_OP_NONE;
  logic [ADDR_W-1:0]   fileAddr = 7'h7f;
  logic [LIT_W-1:0]    branchLiteral = 11'h000;
  logic [LATCH_W-1:0]  pageLatch = 7'h00;
  logic opReady, flushNext, pcLoad, fileWrite;
  logic [PC_W-1:0]     pcValue;
  logic [DATA_W-1:0]   accumulatorReg, fileWrData;
  logic [STATUS_W-1:0] statusReg;
  logic [WDT_W-1:0]    watchdogCounter;
  logic [ADDR_W-1:0]   fileWrAddr;
  int fail_count = 0, compares = 0, cyc = 0, i = 0;

  idcb_exec uut (.core_clk, .srst, .opCode, .opValid, .fileAddr, .resultTarget,
    .branchLiteral, .pageLatch, .watchdogTick, .opReady, .flushNext, .pcLoad, .pcValue,
    .accumulatorReg, .statusReg, .watchdogCounter, .fileWrite, .fileWrAddr, .fileWrData);

  initial forever #5 core_clk = ~core_clk;

  task test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  // Tests need about 1100 cycles; ceiling leaves margin
  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 6000)
    begin
      fail_count++;
      test_done();
    end
  end

  task chk(input logic [14:0] got, input logic [14:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Returns at the edge after the taking edge
  task issue(input idcb_op_t op, input logic t);
    opCode <= op;
    resultTarget <= t;
    opValid <= 1'b1;
    @(posedge core_clk);
    while (opReady !== 1'b1) @(posedge core_clk);
    opValid <= 1'b0;
    @(posedge core_clk);
  endtask : issue

  task fop(input idcb_op_t op, input logic t, input logic [7:0] e, input logic fl,
    input logic ez);
    issue(op, t);
    @(posedge core_clk);
    chk(15'(t ? fileWrData : accumulatorReg), 15'(e));
    chk(15'({fileWrite, t ? fileWrAddr : 7'h7f}), 15'({t, 7'h7f}));
    chk(15'({flushNext, statusReg[ST_ZERO]}), 15'({fl, ez}));
  endtask : fop

  task jmp(input logic [10:0] lit, input logic [6:0] pl, input logic [14:0] e);
    branchLiteral <= lit;
    pageLatch <= pl;
    issue(IDCB_OP_JUMP, 1'b0);
    chk(15'({pcLoad, opReady}), 15'h2);
    chk(pcValue, e);
    chk(15'(statusReg), 15'h1c);
  endtask : jmp

  initial
  begin
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    // First request only once opReady has come up after release
    @(posedge core_clk);
    // Wrap the cell to zero; the flush must mark exactly that step
    do
    begin
      issue(IDCB_OP_INCSZ, 1'b1);
      @(posedge core_clk);
      chk(15'(flushNext), 15'(fileWrData === 8'h00));
      i++;
    end
    while (fileWrData !== 8'h00 && i < 260);
    chk(15'(fileWrData), 15'h00);
    fop(IDCB_OP_INC, 1, 8'h01, 0, 0);
    fop(IDCB_OP_DECSZ, 0, 8'h00, 1, 0);
    fop(IDCB_OP_DEC, 0, 8'h00, 0, 1);
    fop(IDCB_OP_DECSZ, 1, 8'h00, 1, 1);
    fop(IDCB_OP_DEC, 1, 8'hff, 0, 0);
    fop(IDCB_OP_INCSZ, 0, 8'h00, 1, 0);
    fop(IDCB_OP_DECSZ, 1, 8'hfe, 0, 0);
    fop(IDCB_OP_INC, 0, 8'hff, 0, 0);
    // Back-to-back increments: the second must see the first's write
    opCode <= IDCB_OP_INC;
    resultTarget <= 1'b1;
    opValid <= 1'b1;
    repeat (3) @(posedge core_clk);
    opValid <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(15'({fileWrData, statusReg[ST_ZERO]}), 15'h001);
    issue(IDCB_OP_CLRACC, 0);
    chk(15'({accumulatorReg, statusReg[ST_ZERO]}), 15'h001);
    issue(IDCB_OP_KICK, 0);
    chk(15'({watchdogCounter, statusReg}), 15'h001c);
    // Prescaler restarted too, so the next count is a full prescale period away
    repeat ((1 << PRE_W) - 1) @(posedge core_clk);
    chk(15'(watchdogCounter), 15'h000);
    @(posedge core_clk);
    chk(15'(watchdogCounter), 15'h001);
    jmp(11'h7ff, 7'h55, 15'h57ff);
    jmp(11'h000, 7'h2a, 15'h2800);
    test_done();
  end
endmodule : inc_dec_clear_branch_exec_test
